// file: src/alarm_mon_pkg.sv
// Purpose: shared constants and types for the line alarm status monitor
// Assumes: one line bit period per sys_clk_i cycle
// Notes:   status_t field order is the status bit order, bit 7 first
`default_nettype none
package alarm_mon_pkg;
	localparam int NUM_CH = 3;
	localparam int AW     = 8;
	localparam int DW     = 32;
	typedef logic [AW-1:0] addr_t;
	// Status offsets are word indices; byte address is four times each
	localparam addr_t STATUS_IDX [NUM_CH] = '{8'h03, 8'h0B, 8'h13};
	localparam addr_t CTRL_ADDR     = 8'h00;
	localparam addr_t IRQ_STAT_ADDR = 8'h04;
	localparam addr_t IRQ_CLR_ADDR  = 8'h08;
	localparam addr_t IRQ_EN_ADDR   = 8'h10;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam int LOS_ZERO_RUN = 160;
	localparam int DENS_WIN     = 48;
	localparam int DENS_PCT     = 33;
	localparam int DENS_MIN     = (DENS_WIN * DENS_PCT + 99) / 100;
	localparam int ZERO_W       = 8;
	localparam int WIN_W        = $clog2(DENS_WIN + 1);
	localparam int PRBS_LEN      = 15;
	localparam int PRBS_TAP      = 13;
	localparam int PRBS_WIN      = 64;
	localparam int PRBS_ERR_LOSS = 16;
	localparam int PRBS_ERR_LOCK = 1;
	localparam int PWIN_W        = $clog2(PRBS_WIN + 1);
	typedef struct packed {
		logic rx_pulse;
		logic analog_los;
		logic fifo_limit_alarm;
		logic receive_lock_loss;
		logic drive_monitor_fault;
	} line_pins_t;
	localparam int PIN_W = $bits(line_pins_t);
	typedef struct packed {
		logic unused;
		logic prbs_loss;
		logic digital_los;
		logic analog_los;
		logic fifo_limit_alarm;
		logic receive_lock_loss;
		logic line_los;
		logic drive_monitor_fault;
	} status_t;
	typedef struct packed {
		logic [NUM_CH-1:0] e3_mode;
		logic [NUM_CH-1:0] ja_enable;
		logic [NUM_CH-1:0] prbs_enable;
	} ctrl_t;
	localparam int CTRL_W = $bits(ctrl_t);
	localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;
	typedef enum logic {LOS_CLEAR, LOS_DECLARED} los_state_t;
	typedef enum logic {PAT_LOCKED, PAT_LOST} prbs_state_t;
endpackage
`default_nettype wire

// file: src/digital_los_detector.sv
// Purpose: digital loss-of-signal detector for one channel
// Assumes: pulse_i is high for a bit period that carried a pulse
// Notes:   held clear while disabled (E3 operation)
`timescale 1ns/1ps
`default_nettype none
module digital_los_detector
	import alarm_mon_pkg::*;
(
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	input  wire logic enable_i,
	input  wire logic pulse_i,
	output logic      los_o
);
	los_state_t        state_reg, state_next;
	logic [ZERO_W-1:0] zero_reg,  zero_next;
	logic [WIN_W-1:0]  win_reg,   win_next;
	logic [WIN_W-1:0]  ones_reg,  ones_next;

	wire             win_end    = win_reg == WIN_W'(DENS_WIN - 1);
	wire [WIN_W-1:0] ones_total = ones_reg + WIN_W'(pulse_i);
	wire             dense      = ones_total >= WIN_W'(DENS_MIN);

	always_comb begin
		state_next = state_reg;
		zero_next  = '0;
		win_next   = '0;
		ones_next  = '0;
		if (enable_i) begin
			unique case (state_reg)
				LOS_CLEAR: begin
					zero_next = pulse_i ? '0 : zero_reg + 1'b1;
					if (zero_next == ZERO_W'(LOS_ZERO_RUN))
						state_next = LOS_DECLARED;
				end
				LOS_DECLARED: begin
					win_next  = win_end ? '0 : win_reg + 1'b1;
					ones_next = win_end ? '0 : ones_total;
					// Density judged per whole window, not per pulse
					if (win_end && dense)
						state_next = LOS_CLEAR;
				end
			endcase
		end else begin
			state_next = LOS_CLEAR;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= LOS_CLEAR;
			zero_reg  <= '0;
			win_reg   <= '0;
			ones_reg  <= '0;
		end else begin
			state_reg <= state_next;
			zero_reg  <= zero_next;
			win_reg   <= win_next;
			ones_reg  <= ones_next;
		end
	end

	assign los_o = state_reg == LOS_DECLARED;
endmodule
`default_nettype wire

// file: src/prbs_lock_checker.sv
// Purpose: self-synchronising PRBS receiver with lock-loss indication
// Assumes: bit_i is the received data, one bit per clock
// Notes:   lock state judged once per error window
`timescale 1ns/1ps
`default_nettype none
module prbs_lock_checker
	import alarm_mon_pkg::*;
(
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	input  wire logic enable_i,
	input  wire logic bit_i,
	output logic      loss_o
);
	prbs_state_t         state_reg, state_next;
	logic [PRBS_LEN-1:0] shift_reg;
	logic [PWIN_W-1:0]   win_reg;
	logic [PWIN_W-1:0]   err_reg;

	wire predicted = shift_reg[PRBS_LEN-1] ^ shift_reg[PRBS_TAP];
	wire bit_err   = bit_i ^ predicted;
	wire win_end   = win_reg == PWIN_W'(PRBS_WIN - 1);
	wire [PWIN_W-1:0] err_total = err_reg + PWIN_W'(bit_err);

	always_comb begin
		state_next = state_reg;
		if (!enable_i) begin
			state_next = PAT_LOCKED;
		end else if (win_end) begin
			unique case (state_reg)
				PAT_LOCKED: if (err_total >= PWIN_W'(PRBS_ERR_LOSS))
					state_next = PAT_LOST;
				PAT_LOST: if (err_total <= PWIN_W'(PRBS_ERR_LOCK))
					state_next = PAT_LOCKED;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= PAT_LOCKED;
			shift_reg <= '0;
			win_reg   <= '0;
			err_reg   <= '0;
		end else begin
			state_reg <= state_next;
			shift_reg <= {shift_reg[PRBS_LEN-2:0], bit_i};
			win_reg   <= (enable_i && !win_end) ? win_reg + 1'b1 : '0;
			err_reg   <= (enable_i && !win_end) ? err_total : '0;
		end
	end

	assign loss_o = state_reg == PAT_LOST;
endmodule
`default_nettype wire

// file: src/line_alarm_status_monitor.sv
// Purpose: per-channel live alarm status with APB access and interrupt
// Assumes: one line bit period per sys_clk_i cycle; alarm pins asynchronous
// Notes:   status bits follow their conditions; no latching
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module line_alarm_status_monitor
	import alarm_mon_pkg::*;
(
	input  wire logic                     sys_clk_i,
	input  wire logic                     rst_i,
	input  wire logic                     psel_i,
	input  wire logic                     penable_i,
	input  wire logic                     pwrite_i,
	input  wire logic [AW-1:0]            paddr_i,
	input  wire logic [DW-1:0]            pwdata_i,
	output logic      [DW-1:0]            prdata_o,
	output logic                          pready_o,
	output logic                          pslverr_o,
	input  wire line_pins_t [NUM_CH-1:0]  line_pins_i,
	output logic                          irq_o
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	localparam int SW = PIN_W * NUM_CH;

	logic [SW-1:0] pin_s1_reg;
	logic [SW-1:0] pin_s2_reg;
	logic [SW-1:0] pin_s3_reg;
	logic [SW-1:0] pin_filt_reg;

	// A change is taken only once stages two and three agree
	wire [SW-1:0] pin_agree     = ~(pin_s2_reg ^ pin_s3_reg);
	wire [SW-1:0] pin_filt_next = (pin_agree & pin_s3_reg)
	                            | (~pin_agree & pin_filt_reg);

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_s1_reg   <= '0;
			pin_s2_reg   <= '0;
			pin_s3_reg   <= '0;
			pin_filt_reg <= '0;
		end else begin
			pin_s1_reg   <= line_pins_i;
			pin_s2_reg   <= pin_s1_reg;
			pin_s3_reg   <= pin_s2_reg;
			pin_filt_reg <= pin_filt_next;
		end
	end

	line_pins_t [NUM_CH-1:0] pins_f;
	assign pins_f = pin_filt_reg;

	// Line bits already run on the recovered clock; the filter would
	// swallow every single-bit pulse, so they bypass the synchronisers
	wire logic [NUM_CH-1:0] rx_bit;
	for (genvar c = 0; c < NUM_CH; c++) begin : g_rx
		assign rx_bit[c] = line_pins_i[c].rx_pulse;
	end

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	ctrl_t             ctrl_reg;
	logic [NUM_CH-1:0] irq_stat_reg;
	logic [NUM_CH-1:0] irq_en_reg;
	logic [DW-1:0]     prdata_reg;

	wire logic [NUM_CH-1:0] st_hit;
	wire logic [DW-1:0]     rd_word [NUM_CH];
	wire logic [NUM_CH-1:0] chan_evt;
	logic      [NUM_CH-1:0] dig_los;
	logic      [NUM_CH-1:0] prbs_loss;

	wire setup_ph  = psel_i & ~penable_i;
	wire access_ph = psel_i & penable_i;

	wire ctrl_hit    = paddr_i == CTRL_ADDR;
	wire irq_st_hit  = paddr_i == IRQ_STAT_ADDR;
	wire irq_clr_hit = paddr_i == IRQ_CLR_ADDR;
	wire irq_en_hit  = paddr_i == IRQ_EN_ADDR;
	wire any_hit     = ctrl_hit | irq_st_hit | irq_clr_hit
	                 | irq_en_hit | (|st_hit);

	wire wr_ctrl = access_ph & pwrite_i & ctrl_hit;
	wire wr_clr  = access_ph & pwrite_i & irq_clr_hit;
	wire wr_en   = access_ph & pwrite_i & irq_en_hit;
	wire rd_take = setup_ph & ~pwrite_i;

	logic [DW-1:0] st_rd;
	always_comb begin
		st_rd = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			st_rd = st_rd | rd_word[i];
		end
	end

	// Clear register reads as zero
	wire [DW-1:0] rd_mux = st_rd
	                     | (ctrl_hit   ? DW'(ctrl_reg)     : '0)
	                     | (irq_st_hit ? DW'(irq_stat_reg) : '0)
	                     | (irq_en_hit ? DW'(irq_en_reg)   : '0);

	// Read data sampled in setup so it stands through the access phase
	wire [DW-1:0] prdata_next = rd_take ? rd_mux : prdata_reg;

	// Zero wait states; writes to read-only words are ignored quietly
	assign pready_o  = 1'b1;
	assign pslverr_o = access_ph & ~any_hit;
	assign prdata_o  = prdata_reg;

	// ----------------------------------------------------------------
	// Per-channel detectors and status
	// ----------------------------------------------------------------
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		status_t stat_reg;
		status_t stat_next;

		digital_los_detector u_los (
			.sys_clk_i (sys_clk_i),
			.rst_i     (rst_i),
			.enable_i  (~ctrl_reg.e3_mode[c]),
			.pulse_i   (rx_bit[c]),
			.los_o     (dig_los[c])
		);

		prbs_lock_checker u_prbs (
			.sys_clk_i (sys_clk_i),
			.rst_i     (rst_i),
			.enable_i  (ctrl_reg.prbs_enable[c]),
			.bit_i     (rx_bit[c]),
			.loss_o    (prbs_loss[c])
		);

		wire fifo_seen = pins_f[c].fifo_limit_alarm
		               & ctrl_reg.ja_enable[c];
		wire los_any   = pins_f[c].analog_los | dig_los[c];

		always_comb begin
			stat_next                     = STATUS_RESET;
			stat_next.prbs_loss           = prbs_loss[c];
			stat_next.digital_los         = dig_los[c];
			stat_next.analog_los          = pins_f[c].analog_los;
			stat_next.fifo_limit_alarm    = fifo_seen;
			stat_next.receive_lock_loss   = pins_f[c].receive_lock_loss;
			stat_next.line_los            = los_any;
			stat_next.drive_monitor_fault = pins_f[c].drive_monitor_fault;
		end

		always_ff @(posedge sys_clk_i or posedge rst_i) begin
			if (rst_i) begin
				stat_reg <= STATUS_RESET;
			end else begin
				stat_reg <= stat_next;
			end
		end

		assign st_hit[c]   = paddr_i == {STATUS_IDX[c][AW-3:0], 2'b00};
		assign rd_word[c]  = st_hit[c] ? DW'(stat_reg) : '0;
		assign chan_evt[c] = stat_next != stat_reg;
	end

	// ----------------------------------------------------------------
	// Control and interrupt registers
	// ----------------------------------------------------------------
	wire [NUM_CH-1:0] clr_mask = wr_clr ? pwdata_i[NUM_CH-1:0] : '0;

	// A change in the clearing cycle survives the clear
	wire [NUM_CH-1:0] irq_stat_next = (irq_stat_reg & ~clr_mask) | chan_evt;
	wire [NUM_CH-1:0] irq_en_next   = wr_en ? pwdata_i[NUM_CH-1:0] : irq_en_reg;
	wire ctrl_t       ctrl_next     = wr_ctrl ? pwdata_i[CTRL_W-1:0] : ctrl_reg;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_reg     <= CTRL_RESET;
			irq_stat_reg <= '0;
			irq_en_reg   <= '0;
			prdata_reg   <= '0;
		end else begin
			ctrl_reg     <= ctrl_next;
			irq_stat_reg <= irq_stat_next;
			irq_en_reg   <= irq_en_next;
			prdata_reg   <= prdata_next;
		end
	end

	assign irq_o = |(irq_stat_reg & irq_en_reg);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	// Zero-run reference for channel 0, saturating
	logic [ZERO_W-1:0] zrun_reg;
	wire  zrun_hold = rx_bit[0] | ctrl_reg.e3_mode[0];
	wire  zrun_full = &zrun_reg;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			zrun_reg <= '0;
		end else if (zrun_hold) begin
			zrun_reg <= '0;
		end else if (!zrun_full) begin
			zrun_reg <= zrun_reg + 1'b1;
		end
	end

	// Recent channel 0 line bits and pattern misses, newest in bit 0
	logic [DENS_WIN-1:0] hist_reg;
	logic [PRBS_WIN-1:0] miss_reg;
	wire  ref_miss = rx_bit[0] ^ hist_reg[PRBS_LEN-1] ^ hist_reg[PRBS_TAP];

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			hist_reg <= '0;
			miss_reg <= '0;
		end else begin
			hist_reg <= {hist_reg[DENS_WIN-2:0], rx_bit[0]};
			miss_reg <= {miss_reg[PRBS_WIN-2:0], ref_miss};
		end
	end

	chk_status_upper: assert property (
		rd_take && (|st_hit) |=> prdata_o[DW-1:7] == '0
	) else $error("status read shows bits above 6");

	chk_read_value: assert property (
		rd_take && st_hit[0] |=> prdata_o == DW'($past(g_ch[0].stat_reg))
	) else $error("status read differs from live state");

	chk_los_combined: assert property (
		g_ch[0].stat_reg.line_los
			== ($past(pins_f[0].analog_los) | $past(dig_los[0]))
	) else $error("bit 1 is not analog OR digital loss");

	chk_digital_bit: assert property (
		g_ch[1].stat_reg.digital_los == $past(dig_los[1])
	) else $error("digital loss bit does not follow detector");

	chk_prbs_bit: assert property (
		g_ch[2].stat_reg.prbs_loss == $past(prbs_loss[2])
	) else $error("pattern loss bit does not follow checker");

	chk_prbs_disabled: assert property (
		!ctrl_reg.prbs_enable[0] |=> ##1 !g_ch[0].stat_reg.prbs_loss
	) else $error("pattern loss shown with checker off");

	chk_fifo_gate: assert property (
		!ctrl_reg.ja_enable[0] |=> !g_ch[0].stat_reg.fifo_limit_alarm
	) else $error("fifo alarm shown with attenuator off");

	chk_los_declare_run: assert property (
		$rose(dig_los[0]) |-> zrun_reg >= LOS_ZERO_RUN
	) else $error("digital loss declared before the zero run");

	chk_los_declare_late: assert property (
		zrun_reg >= (LOS_ZERO_RUN + DENS_WIN) |-> dig_los[0]
	) else $error("digital loss missing after long zero run");

	chk_irq_sticky: assert property (
		chan_evt[0] |=> irq_stat_reg[0] [*2]
	) else $error("change event lost or not sticky");

	chk_irq_mask: assert property (
		irq_en_reg == '0 |-> !irq_o
	) else $error("interrupt raised while all masked");

	chk_read_ch1: assert property (
		rd_take && st_hit[1] |=> prdata_o == DW'($past(g_ch[1].stat_reg))
	) else $error("channel 1 read differs from live state");

	chk_read_ch2: assert property (
		rd_take && st_hit[2] |=> prdata_o == DW'($past(g_ch[2].stat_reg))
	) else $error("channel 2 read differs from live state");

	chk_reset_clear: assert property (
		$fell(rst_i) |-> g_ch[0].stat_reg == STATUS_RESET
			&& g_ch[1].stat_reg == STATUS_RESET
			&& g_ch[2].stat_reg == STATUS_RESET && !irq_o
	) else $error("status or interrupt not clear after reset");

	chk_unused_zero: assert property (
		!(g_ch[0].stat_reg.unused | g_ch[1].stat_reg.unused | g_ch[2].stat_reg.unused)
	) else $error("unused status bit set");

	chk_analog_bit: assert property (
		g_ch[1].stat_reg.analog_los == $past(pins_f[1].analog_los)
	) else $error("analog loss bit does not follow its pin");

	chk_lock_bit: assert property (
		g_ch[2].stat_reg.receive_lock_loss == $past(pins_f[2].receive_lock_loss)
	) else $error("receive lock loss bit does not follow its pin");

	chk_drive_bit: assert property (
		g_ch[1].stat_reg.drive_monitor_fault == $past(pins_f[1].drive_monitor_fault)
	) else $error("drive monitor bit does not follow its pin");

	chk_fifo_follow: assert property (
		ctrl_reg.ja_enable[2] |=> g_ch[2].stat_reg.fifo_limit_alarm
			== $past(pins_f[2].fifo_limit_alarm)
	) else $error("fifo alarm not shown with attenuator on");

	chk_los_clear_dense: assert property (
		$fell(dig_los[0]) && !$past(ctrl_reg.e3_mode[0])
			|-> $countones(hist_reg) >= DENS_MIN
	) else $error("digital loss cleared below the pulse density");

	chk_los_no_clear: assert property (
		dig_los[0] && !ctrl_reg.e3_mode[0] && zrun_reg >= DENS_WIN |=> dig_los[0]
	) else $error("digital loss cleared without pulses");

	chk_prbs_loss_count: assert property (
		$rose(prbs_loss[0]) |-> $countones(miss_reg) >= PRBS_ERR_LOSS
	) else $error("pattern loss declared with few errors");

	chk_prbs_lock_count: assert property (
		$fell(prbs_loss[0]) && $past(ctrl_reg.prbs_enable[0])
			|-> $countones(miss_reg) <= PRBS_ERR_LOCK
	) else $error("pattern lock regained with many errors");

	chk_prdata_hold: assert property (
		!rd_take |=> $stable(prdata_o)
	) else $error("read data changed outside a read setup");

	chk_irq_set_wins: assert property (
		chan_evt[1] |=> irq_stat_reg[1]
	) else $error("change event lost to a clear");

	cov_los_declared: cover property ($rose(dig_los[0]));
	cov_los_cleared: cover property ($fell(dig_los[0]));
	cov_prbs_lost: cover property ($rose(prbs_loss[0]));
	cov_irq_raised: cover property ($rose(irq_o));
	cov_prbs_relocked: cover property ($fell(prbs_loss[0]));
endmodule
`default_nettype wire

// file: testbench/line_alarm_status_monitor_bench.sv
// Purpose: self-checking bench for line_alarm_status_monitor
// Assumes: zero-wait APB slave; alarm pins seen about five edges late
// Notes:   reads queue their expectation; a monitor compares at access
`timescale 1ns/1ps
`default_nettype none
module line_alarm_status_monitor_bench
	import alarm_mon_pkg::*;
;
	typedef struct packed {
		logic [DW-1:0] val;
		logic [DW-1:0] msk;
		logic          err;
	} note_t;
	logic               clk         = 1'b0;
	logic               rst         = 1'b1;
	logic               psel        = 1'b0;
	logic               pen         = 1'b0;
	logic               pwr         = 1'b0;
	logic [AW-1:0]      paddr       = 8'h00;
	logic [DW-1:0]      pwdata      = 32'h0;
	logic [DW-1:0]      prdata;
	logic               pready;
	logic               pslverr;
	logic               irq;
	logic [NUM_CH-1:0]  alos        = 3'h0;
	logic [NUM_CH-1:0]  fla         = 3'h0;
	logic [NUM_CH-1:0]  rll         = 3'h0;
	logic [NUM_CH-1:0]  dmf         = 3'h0;
	logic [NUM_CH-1:0]  ja          = 3'h0;
	logic [NUM_CH-1:0]  rx          = 3'h0;
	logic [14:0]        sr          = 15'h0001;
	logic [1:0]         ph          = 2'h0;
	logic [2:0]         j;
	int                 rx_mode     = 0;
	int                 err_total   = 0;
	int                 checks_done = 0;
	line_pins_t [NUM_CH-1:0] pins;
	note_t              notes[$];

	always #50 clk = ~clk;

	line_alarm_status_monitor dut_u (
		.sys_clk_i   (clk),
		.rst_i       (rst),
		.psel_i      (psel),
		.penable_i   (pen),
		.pwrite_i    (pwr),
		.paddr_i     (paddr),
		.pwdata_i    (pwdata),
		.prdata_o    (prdata),
		.pready_o    (pready),
		.pslverr_o   (pslverr),
		.line_pins_i (pins),
		.irq_o       (irq)
	);

	// ----------------------------------------
	// Line stimulus
	// ----------------------------------------
	always_comb begin
		for (int c = 0; c < NUM_CH; c++)
			pins[c] = {rx[c], alos[c], fla[c], rll[c], dmf[c]};
	end

	// Mode 2 is exactly one pulse in four: 25 percent never clears
	always @(posedge clk) begin
		sr <= {sr[13:0], sr[14] ^ sr[13]};
		ph <= ph + 2'h1;
		rx[2:1] <= ~rx[2:1];
		case (rx_mode)
			0: rx[0] <= ~rx[0];
			1: rx[0] <= 1'b0;
			2: rx[0] <= (ph == 2'h0);
			3: rx[0] <= 1'($urandom);
			default: rx[0] <= sr[14] ^ sr[13];
		endcase
	end

	// ----------------------------------------
	// Bus tasks and monitor
	// ----------------------------------------
	task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 100) begin
			n++;
			@(posedge clk);
		end
		if (n == 100)
			err_total++;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] v, input logic e);
		notes.push_back('{v, 32'hFFFFFFFF, e});
		apb(1'b0, a, 32'h0);
	endtask

	function automatic logic [7:0] st(input int c, input logic dl, input logic pl);
		return {1'b0, pl, dl, alos[c], fla[c] & ja[c], rll[c], alos[c] | dl, dmf[c]};
	endfunction

	task automatic rs(input int c, input logic dl, input logic pl);
		rd(addr_t'(STATUS_IDX[c] << 2), DW'(st(c, dl, pl)), 1'b0);
	endtask

	task automatic ck(input logic v);
		checks_done++;
		if (irq !== v) begin
			err_total++;
			$display("unexpected at %0t: irq %h want %h", $time, irq, v);
		end
	endtask

	always @(posedge clk) begin
		if (psel && pen && !pwr && pready === 1'b1) begin
			note_t n;
			n = notes.pop_front();
			checks_done++;
			if ((prdata & n.msk) !== (n.val & n.msk) || pslverr !== n.err) begin
				err_total++;
				$display("unexpected at %0t: got %h/%h want %h/%h", $time, prdata, pslverr,
					n.val, n.err);
			end
		end
	end

	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		close_out();
	end

	initial begin
		void'($urandom(32'hAD6B));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (int c = 0; c < NUM_CH; c++)
			rs(c, 1'b0, 1'b0);
		rd(CTRL_ADDR, 32'h0, 1'b0);
		$display("done: reset values");
		for (int k = 0; k < 6; k++) begin
			j = 3'($urandom);
			ja = j;
			{alos, fla, rll, dmf} <= 12'($urandom);
			apb(1'b1, CTRL_ADDR, DW'({j, 3'h0}));
			repeat (8) @(posedge clk);
			for (int c = 0; c < NUM_CH; c++)
				rs(c, 1'b0, 1'b0);
		end
		rd(8'h3C, 32'h0, 1'b1);
		rd(8'h0D, 32'h0, 1'b1);
		apb(1'b1, 8'h0C, 32'hFFFFFFFF);
		rs(0, 1'b0, 1'b0);
		$display("done: plain alarms and decode");
		rx_mode <= 1;
		repeat (150) @(posedge clk);
		rs(0, 1'b0, 1'b0);
		repeat (20) @(posedge clk);
		rs(0, 1'b1, 1'b0);
		rx_mode <= 2;
		repeat (200) @(posedge clk);
		rs(0, 1'b1, 1'b0);
		rx_mode <= 0;
		repeat (120) @(posedge clk);
		rs(0, 1'b0, 1'b0);
		// E3 on channel 0 keeps digital loss clear through a dead line
		apb(1'b1, CTRL_ADDR, DW'({3'h1, j, 3'h0}));
		rx_mode <= 1;
		repeat (200) @(posedge clk);
		rs(0, 1'b0, 1'b0);
		$display("done: digital loss of signal");
		rx_mode <= 4;
		repeat (20) @(posedge clk);
		apb(1'b1, CTRL_ADDR, DW'({j, 3'h1}));
		repeat (200) @(posedge clk);
		rs(0, 1'b0, 1'b0);
		rx_mode <= 3;
		repeat (200) @(posedge clk);
		rs(0, 1'b0, 1'b1);
		rx_mode <= 4;
		repeat (200) @(posedge clk);
		rs(0, 1'b0, 1'b0);
		$display("done: pattern lock");
		apb(1'b1, IRQ_CLR_ADDR, 32'h7);
		repeat (2) @(posedge clk);
		rd(IRQ_STAT_ADDR, 32'h0, 1'b0);
		dmf[1] <= ~dmf[1];
		repeat (8) @(posedge clk);
		rd(IRQ_STAT_ADDR, 32'h2, 1'b0);
		ck(1'b0);
		apb(1'b1, IRQ_EN_ADDR, 32'h2);
		repeat (2) @(posedge clk);
		ck(1'b1);
		apb(1'b1, IRQ_CLR_ADDR, 32'h2);
		repeat (2) @(posedge clk);
		ck(1'b0);
		rd(IRQ_EN_ADDR, 32'h2, 1'b0);
		rs(1, 1'b0, 1'b0);
		$display("done: interrupt");
		close_out();
	end
endmodule
`default_nettype wire
